// file: shared/pwm_cfg_pkg.sv
package pwm_cfg_pkg;

   // ==========================================================
   // Sizes
   localparam int          CHANNELS      = 3;
   localparam int          CHAN_W        = 2;
   localparam int          MATCH_W       = 16;
   localparam int          SFR_W         = 8;

   // ==========================================================
   // Special-function-register addresses
   localparam logic [7:0]  CFG_ADDR      = 8'hF7;
   localparam logic [7:0]  MATCH_LOW_ADDR  [CHANNELS] = '{8'hFB, 8'hE9, 8'hEB};
   localparam logic [7:0]  MATCH_HIGH_ADDR [CHANNELS] = '{8'hFC, 8'hEA, 8'hEC};

   // ==========================================================
   // Configuration register layout
   localparam int          VIEW_BIT      = 7;
   localparam int          IRQ_EN_BIT    = 6;
   localparam int          FLAG_BIT      = 5;
   localparam int          LEN_LSB       = 0;
   localparam int          LEN_W         = 2;
   localparam logic [7:0]  CFG_RESET     = 8'h00;
   localparam logic [7:0]  CFG_WMASK     = 8'hE3;
   localparam logic [1:0]  LEN_8_BITS    = 2'h0;
   localparam logic [15:0] BASE_CYCLE_MASK = 16'h00FF;
   localparam logic [15:0] FULL_MASK     = 16'hFFFF;
   localparam logic [15:0] MATCH_RESET   = 16'h0000;
   localparam logic [7:0]  READ_IDLE     = 8'h00;

   // ==========================================================
   // Read source and copy sequencer states
   typedef enum logic [1:0] {RD_NONE, RD_CFG, RD_CMP, RD_RLD} rd_src_t;
   typedef enum logic {CP_IDLE, CP_RUN} copy_state_t;

endpackage : pwm_cfg_pkg

// file: shared/reload_mem_if.sv
`timescale 1ns/1ns
`default_nettype none
interface reload_mem_if;
   import pwm_cfg_pkg::*;
   logic [CHAN_W-1:0]  addr;
   logic               we;
   logic [1:0]         be;
   logic [MATCH_W-1:0] wdata;
   logic [MATCH_W-1:0] rdata;
   modport ctrl (output addr, output we, output be, output wdata, input rdata);
   modport mem  (input addr, input we, input be, input wdata, output rdata);
endinterface : reload_mem_if
`default_nettype wire

// file: logic/reload_mem.sv
`timescale 1ns/1ns
`default_nettype none
module reload_mem
   import pwm_cfg_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   reset_n,
   reload_mem_if.mem   port
);

   // ==========================================================
   // Storage, one word per channel, byte writable
   logic [MATCH_W-1:0] word_reg  [CHANNELS];
   logic [MATCH_W-1:0] word_next [CHANNELS];
   logic [MATCH_W-1:0] rdata_reg;
   logic [MATCH_W-1:0] rdata_next;

   always_comb
   begin
      for (int i = 0; i < CHANNELS; i++)
      begin
         word_next[i] = word_reg[i];
         if (port.we && port.addr == CHAN_W'(i))
         begin
            if (port.be[0])
               word_next[i][7:0] = port.wdata[7:0];
            if (port.be[1])
               word_next[i][15:8] = port.wdata[15:8];
         end
      end
      // Idle sequencer parks past the last channel; keep the read defined there
      rdata_next = MATCH_RESET;
      if (port.addr < CHAN_W'(CHANNELS))
         rdata_next = word_reg[port.addr];
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < CHANNELS; i++)
            word_reg[i] <= MATCH_RESET;
         rdata_reg <= MATCH_RESET;
      end
      else
      begin
         for (int i = 0; i < CHANNELS; i++)
            word_reg[i] <= word_next[i];
         rdata_reg <= rdata_next;
      end
   end

   assign port.rdata = rdata_reg;

endmodule : reload_mem
`default_nettype wire

// file: logic/pwm_cycle_config.sv
`timescale 1ns/1ns
`default_nettype none
module pwm_cycle_config
   import pwm_cfg_pkg::*;
(
   input  wire logic                               clk,
   input  wire logic                               reset_n,
   input  wire logic [SFR_W-1:0]                   sfr_addr,
   input  wire logic                               sfr_wr,
   input  wire logic                               sfr_rd,
   input  wire logic [SFR_W-1:0]                   sfr_wdata,
   input  wire logic                               counter_tick,
   input  wire logic [MATCH_W-1:0]                 main_counter,
   input  wire logic [CHANNELS-1:0]                chan_pwm_en,
   input  wire logic [CHANNELS-1:0]                chan_pwm16,
   output logic [SFR_W-1:0]                        sfr_rdata,
   output logic                                    sfr_rdata_valid,
   output logic [SFR_W-1:0]                        config_value,
   output logic                                    cycle_wrap_irq,
   output logic [CHANNELS-1:0]                     chan_wrap,
   output logic [CHANNELS-1:0][MATCH_W-1:0]        chan_match
);

   // ==========================================================
   // State
   logic [SFR_W-1:0]                  cfg_reg, cfg_next;
   logic                              irq_reg, irq_next;
   logic [CHANNELS-1:0]               wrap_reg, wrap_next;
   logic [CHANNELS-1:0][MATCH_W-1:0]  match_reg, match_next;
   logic [SFR_W-1:0]                  rdata_reg, rdata_next;
   logic                              rvalid_reg, rvalid_next;
   rd_src_t                           rsrc_reg, rsrc_next;
   logic [CHAN_W-1:0]                 rchan_reg, rchan_next;
   logic                              rhigh_reg, rhigh_next;
   copy_state_t                       cstate_reg, cstate_next;
   logic [CHAN_W-1:0]                 cchan_reg, cchan_next;
   logic                              cpend_reg, cpend_next;
   logic [CHAN_W-1:0]                 cpchan_reg, cpchan_next;
   logic [CHANNELS-1:0]               elig_reg, elig_next;

   // ==========================================================
   // Address decode
   logic                cfg_hit;
   logic                chan_hit;
   logic [CHAN_W-1:0]   hit_chan;
   logic                hit_high;
   logic                view_reload;
   logic                cpu_mem;
   logic                cyc_wrap;
   logic                full_wrap;
   logic [MATCH_W-1:0]  cyc_mask;
   logic [LEN_W-1:0]    len_sel;

   reload_mem_if mem_bus ();

   reload_mem u_reload_mem (
      .clk     (clk),
      .reset_n (reset_n),
      .port    (mem_bus)
   );

   always_comb
   begin
      cfg_hit  = (sfr_addr == CFG_ADDR);
      chan_hit = 1'b0;
      hit_chan = '0;
      hit_high = 1'b0;
      for (int i = 0; i < CHANNELS; i++)
      begin
         if (sfr_addr == MATCH_LOW_ADDR[i] || sfr_addr == MATCH_HIGH_ADDR[i])
         begin
            chan_hit = 1'b1;
            hit_chan = CHAN_W'(i);
            hit_high = (sfr_addr == MATCH_HIGH_ADDR[i]);
         end
      end
      view_reload = cfg_reg[VIEW_BIT];
      cpu_mem     = chan_hit && view_reload && (sfr_wr || sfr_rd);
   end

   // ==========================================================
   // Cycle length and overflow detection
   always_comb
   begin
      len_sel   = cfg_reg[LEN_LSB +: LEN_W];
      cyc_mask  = MATCH_W'({BASE_CYCLE_MASK, 8'hFF} >> (4'h8 - {2'h0, len_sel}));
      cyc_wrap  = counter_tick && ((main_counter & cyc_mask) == cyc_mask);
      full_wrap = counter_tick && (main_counter == FULL_MASK);
   end

   // ==========================================================
   // Per-channel cycle boundary
   generate
      for (genvar g = 0; g < CHANNELS; g++)
      begin : g_chan
         // A 16-bit channel wraps on the full counter only
         assign wrap_next[g] = chan_pwm_en[g] && (chan_pwm16[g] ? full_wrap : cyc_wrap);
      end
   endgenerate

   // ==========================================================
   // Memory port: the processor wins; the copy stalls for every cycle of processor access
   always_comb
   begin
      mem_bus.addr  = cpu_mem ? hit_chan : cchan_reg;
      mem_bus.we    = cpu_mem && sfr_wr;
      mem_bus.be    = hit_high ? 2'h2 : 2'h1;
      mem_bus.wdata = {sfr_wdata, sfr_wdata};
   end

   // ==========================================================
   // Configuration, interrupt, copy sequencer and read path
   always_comb
   begin
      cfg_next    = cfg_reg;
      match_next  = match_reg;
      cstate_next = cstate_reg;
      cchan_next  = cchan_reg;
      cpend_next  = 1'b0;
      cpchan_next = cchan_reg;
      elig_next   = elig_reg;
      rsrc_next   = RD_NONE;
      rchan_next  = hit_chan;
      rhigh_next  = hit_high;
      rvalid_next = 1'b0;
      rdata_next  = rdata_reg;

      if (sfr_wr && cfg_hit)
         cfg_next = sfr_wdata & CFG_WMASK;
      // A hardware set in the same cycle as a clearing write still wins
      if (cyc_wrap)
         cfg_next[FLAG_BIT] = 1'b1;

      // Copy from reload words finishes within a few cycles, well inside one PWM cycle
      if (cpend_reg && elig_reg[cpchan_reg])
         match_next[cpchan_reg] = mem_bus.rdata;
      case (cstate_reg)
         CP_IDLE:
         begin
            if (cyc_wrap && len_sel != LEN_8_BITS)
            begin
               cstate_next = CP_RUN;
               cchan_next  = '0;
               elig_next   = chan_pwm_en & ~chan_pwm16;
            end
         end
         CP_RUN:
         begin
            if (!cpu_mem)
            begin
               cpend_next = 1'b1;
               cchan_next = cchan_reg + CHAN_W'(1);
               if (cchan_reg == CHAN_W'(CHANNELS - 1))
                  cstate_next = CP_IDLE;
            end
         end
         default:
            cstate_next = CP_IDLE;
      endcase

      if (sfr_wr && chan_hit && !view_reload)
      begin
         if (hit_high)
            match_next[hit_chan][15:8] = sfr_wdata;
         else
            match_next[hit_chan][7:0] = sfr_wdata;
      end

      if (sfr_rd)
      begin
         if (cfg_hit)
            rsrc_next = RD_CFG;
         else if (chan_hit)
            rsrc_next = view_reload ? RD_RLD : RD_CMP;
      end
      case (rsrc_reg)
         RD_CFG:
         begin
            rdata_next  = cfg_reg & CFG_WMASK;
            rvalid_next = 1'b1;
         end
         RD_CMP:
         begin
            rdata_next  = rhigh_reg ? match_reg[rchan_reg][15:8] : match_reg[rchan_reg][7:0];
            rvalid_next = 1'b1;
         end
         RD_RLD:
         begin
            rdata_next  = rhigh_reg ? mem_bus.rdata[15:8] : mem_bus.rdata[7:0];
            rvalid_next = 1'b1;
         end
         default:
            rvalid_next = 1'b0;
      endcase

      irq_next = cfg_next[FLAG_BIT] && cfg_next[IRQ_EN_BIT];
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         cfg_reg    <= CFG_RESET;
         irq_reg    <= 1'b0;
         wrap_reg   <= '0;
         match_reg  <= '0;
         rdata_reg  <= READ_IDLE;
         rvalid_reg <= 1'b0;
         rsrc_reg   <= RD_NONE;
         rchan_reg  <= '0;
         rhigh_reg  <= 1'b0;
         cstate_reg <= CP_IDLE;
         cchan_reg  <= '0;
         cpend_reg  <= 1'b0;
         cpchan_reg <= '0;
         elig_reg   <= '0;
      end
      else
      begin
         cfg_reg    <= cfg_next;
         irq_reg    <= irq_next;
         wrap_reg   <= wrap_next;
         match_reg  <= match_next;
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
         rsrc_reg   <= rsrc_next;
         rchan_reg  <= rchan_next;
         rhigh_reg  <= rhigh_next;
         cstate_reg <= cstate_next;
         cchan_reg  <= cchan_next;
         cpend_reg  <= cpend_next;
         cpchan_reg <= cpchan_next;
         elig_reg   <= elig_next;
      end
   end

   assign sfr_rdata       = rdata_reg;
   assign sfr_rdata_valid = rvalid_reg;
   assign config_value    = cfg_reg;
   assign cycle_wrap_irq  = irq_reg;
   assign chan_wrap       = wrap_reg;
   assign chan_match      = match_reg;

endmodule : pwm_cycle_config
`default_nettype wire

// file: dv/pwm_cycle_config_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// =====
// Port checker
module pwm_cycle_config_monitor
   import pwm_cfg_pkg::*;
(
   input wire logic                        clk,
   input wire logic                        reset_n,
   input wire logic [SFR_W-1:0]            sfr_addr,
   input wire logic                        sfr_wr,
   input wire logic                        sfr_rd,
   input wire logic [SFR_W-1:0]            sfr_wdata,
   input wire logic                        counter_tick,
   input wire logic [MATCH_W-1:0]          main_counter,
   input wire logic [CHANNELS-1:0]         chan_pwm16,
   input wire logic [SFR_W-1:0]            sfr_rdata,
   input wire logic                        sfr_rdata_valid,
   input wire logic [SFR_W-1:0]            config_value,
   input wire logic                        cycle_wrap_irq,
   input wire logic [CHANNELS-1:0]         chan_wrap,
   input wire logic [CHANNELS-1:0][MATCH_W-1:0] chan_match
);
   logic [15:0] wmask;
   // Mask of the counter bits that form one cycle
   assign wmask = (16'h0100 << config_value[1:0]) - 16'h0001;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
chk_irq_mirror:
   assert property (cycle_wrap_irq == (config_value[6] & config_value[5])) else $error("irq not flag and enable");
chk_unused_zero:
   assert property (config_value[4:2] == 3'h0) else $error("unused bits not zero");
chk_wrap_sets:
   assert property (counter_tick && (main_counter & wmask) == wmask |=> config_value[5]) else $error("flag not set");
chk_flag_holds:
   assert property (config_value[5] && !(sfr_wr && sfr_addr == CFG_ADDR) |=> config_value[5])
      else $error("flag cleared by hardware");
chk_cfg_write:
   assert property (sfr_wr && sfr_addr == CFG_ADDR |=> (config_value & 8'hC3) == ($past(sfr_wdata) & 8'hC3))
      else $error("config write lost");
chk_read_late:
   assert property (sfr_rd && sfr_addr == CFG_ADDR |-> ##2 sfr_rdata_valid && sfr_rdata[4:2] == 3'h0)
      else $error("config read wrong");
chk_wrap_cause:
   assert property (!counter_tick |=> chan_wrap == 3'h0) else $error("wrap without tick");
chk_wide_ignore:
   assert property (counter_tick && main_counter != 16'hFFFF |=> (chan_wrap & $past(chan_pwm16)) == 3'h0)
      else $error("16-bit channel wrapped early");
chk_reset_zero:
   assert property (disable iff (1'b0) !reset_n |=> config_value == CFG_RESET && chan_match == '0)
      else $error("reset values wrong");
endmodule : pwm_cycle_config_monitor
bind pwm_cycle_config pwm_cycle_config_monitor u_pwm_cycle_config_monitor (
   .clk             (clk),
   .reset_n         (reset_n),
   .sfr_addr        (sfr_addr),
   .sfr_wr          (sfr_wr),
   .sfr_rd          (sfr_rd),
   .sfr_wdata       (sfr_wdata),
   .counter_tick    (counter_tick),
   .main_counter    (main_counter),
   .chan_pwm16      (chan_pwm16),
   .sfr_rdata       (sfr_rdata),
   .sfr_rdata_valid (sfr_rdata_valid),
   .config_value    (config_value),
   .cycle_wrap_irq  (cycle_wrap_irq),
   .chan_wrap       (chan_wrap),
   .chan_match      (chan_match)
);
`default_nettype wire

// file: dv/pwm_cycle_config_tb.sv
`timescale 1ns/1ns
`default_nettype none
module pwm_cycle_config_tb
   import pwm_cfg_pkg::*;
;
   logic clk = 1'b0, reset_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, counter_tick = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, config_value;
   logic [15:0] main_counter = 16'h0000;
   // Channel 1 outside PWM, channel 2 in 16-bit mode
   logic [2:0] chan_pwm_en = 3'h5, chan_pwm16 = 3'h4, chan_wrap;
   logic sfr_rdata_valid, cycle_wrap_irq;
   logic [CHANNELS-1:0][MATCH_W-1:0] chan_match;
   int err_count = 0, cmp_count = 0, m_cfg = 0;
   int m_cmp[3] = '{default:0}, m_rld[3] = '{default:0};
   pwm_cycle_config u_pwm_cycle_config (
      .clk             (clk),
      .reset_n         (reset_n),
      .sfr_addr        (sfr_addr),
      .sfr_wr          (sfr_wr),
      .sfr_rd          (sfr_rd),
      .sfr_wdata       (sfr_wdata),
      .counter_tick    (counter_tick),
      .main_counter    (main_counter),
      .chan_pwm_en     (chan_pwm_en),
      .chan_pwm16      (chan_pwm16),
      .sfr_rdata       (sfr_rdata),
      .sfr_rdata_valid (sfr_rdata_valid),
      .config_value    (config_value),
      .cycle_wrap_irq  (cycle_wrap_irq),
      .chan_wrap       (chan_wrap),
      .chan_match      (chan_match)
   );
   always #2 clk = ~clk;
   // =====
   // Checks and model
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task results;
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : results
   function automatic int exp_rd(input logic [7:0] a);
      exp_rd = (a == CFG_ADDR) ? m_cfg : -1;
      for (int k = 0; k < 3; k++)
      begin
         if (a == MATCH_LOW_ADDR[k]) exp_rd = (m_cfg[7] ? m_rld[k] : m_cmp[k]) & 255;
         if (a == MATCH_HIGH_ADDR[k]) exp_rd = (m_cfg[7] ? m_rld[k] : m_cmp[k]) >> 8;
      end
   endfunction : exp_rd
   task flags;
      @(negedge clk);
      chk("flag", m_cfg[5], config_value[5]);
      chk("irq", m_cfg[5] & m_cfg[6], cycle_wrap_irq);
      chk("config_value", m_cfg[7:0], config_value);
      @(posedge clk);
   endtask : flags
   task mchk;
      // Sample away from the launching edge so a same-edge update cannot race the check
      @(negedge clk);
      for (int k = 0; k < 3; k++) chk("chan_match", m_cmp[k], chan_match[k]);
      @(posedge clk);
   endtask : mchk
   // =====
   // Bus and counter drivers, entered just after a rising edge
   task wr(input logic [7:0] a, input logic [7:0] d);
      if (a == CFG_ADDR) m_cfg = d & 8'hE3;
      for (int k = 0; k < 3; k++)
      begin
         if (a == MATCH_LOW_ADDR[k] && m_cfg[7]) m_rld[k][7:0] = d;
         if (a == MATCH_LOW_ADDR[k] && !m_cfg[7]) m_cmp[k][7:0] = d;
         if (a == MATCH_HIGH_ADDR[k] && m_cfg[7]) m_rld[k][15:8] = d;
         if (a == MATCH_HIGH_ADDR[k] && !m_cfg[7]) m_cmp[k][15:8] = d;
      end
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk) sfr_wr <= 1'b0;
      @(posedge clk);
   endtask : wr
   task rd(input logic [7:0] a);
      int e;
      logic v;
      e = exp_rd(a);
      v = 1'b0;
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk) sfr_rd <= 1'b0;
      // Bounded wait; a missing answer shows up as a valid mismatch
      repeat (4)
      begin
         @(negedge clk);
         if (sfr_rdata_valid === 1'b1 && !v) chk("sfr_rdata", e[15:0], sfr_rdata);
         if (sfr_rdata_valid === 1'b1) v = 1'b1;
      end
      chk("sfr_rdata_valid", e >= 0, v);
      @(posedge clk);
   endtask : rd
   task tick(input logic [15:0] c);
      int m;
      logic w;
      m = (256 << m_cfg[1:0]) - 1;
      w = (c & m) == m;
      main_counter <= c;
      counter_tick <= 1'b1;
      @(posedge clk) counter_tick <= 1'b0;
      @(negedge clk);
      chk("chan_wrap", w ? chan_pwm_en & (~chan_pwm16 | {3{c == 16'hFFFF}}) : 3'h0, chan_wrap);
      if (w) m_cfg[5] = 1;
      for (int k = 0; k < 3; k++)
         if (w && m_cfg[1:0] != 0 && chan_pwm_en[k] && !chan_pwm16[k]) m_cmp[k] = m_rld[k];
      // Copies land within a few cycles of the wrap
      repeat (6) @(negedge clk);
      mchk();
      flags();
   endtask : tick
   // =====
   // Main sequence
   initial
   begin
      void'($urandom(40));
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(CFG_ADDR);
      mchk();
      wr(CFG_ADDR, 8'hFF);
      rd(CFG_ADDR);
      flags();
      wr(CFG_ADDR, 8'h00);
      flags();
      rd(8'h00);
      for (int v = 0; v < 2; v++)
      begin
         wr(CFG_ADDR, v ? 8'h80 : 8'h00);
         for (int k = 0; k < 3; k++)
         begin
            wr(MATCH_LOW_ADDR[k], 8'($urandom));
            wr(MATCH_HIGH_ADDR[k], 8'($urandom));
         end
      end
      for (int v = 0; v < 2; v++)
      begin
         wr(CFG_ADDR, v ? 8'h00 : 8'h80);
         for (int k = 0; k < 3; k++) rd(MATCH_LOW_ADDR[k]);
         for (int k = 0; k < 3; k++) rd(MATCH_HIGH_ADDR[k]);
      end
      mchk();
      for (int s = 0; s < 4; s++)
      begin
         wr(CFG_ADDR, 8'h40 | 8'(s));
         tick(16'((256 << s) - 1) >> 1);
         tick(16'((256 << s) - 1));
         wr(CFG_ADDR, 8'h40 | 8'(s));
         flags();
      end
      tick(16'hFFFF);
      results();
   end
endmodule : pwm_cycle_config_tb
`default_nettype wire
